// file: rtl/ebtp_timer.v
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "ebtp_defs.vh"

module ebtp_timer (
   input  wire       i_mclk,
   input  wire       i_rst,
   input  wire [3:0] i_addr,
   input  wire [7:0] i_wdata,
   input  wire       i_wr,
   input  wire       i_rd,
   input  wire       i_fast_osc_tick,
   input  wire       i_slow_osc_tick,
   input  wire       i_port_a_pin0,
   input  wire       i_port_a_pin4,
   output reg  [7:0] o_rdata,
   output reg        o_irq,
   output reg        o_scaled_timer_clock,
   output reg        o_port_a_pin3_out,
   output reg        o_port_a_pin3_oe_n,
   output reg        o_port_a_pin4_out,
   output reg        o_port_a_pin4_oe_n
);

   // ***************************************************
   // registers
   // ***************************************************
   reg  [7:0] control_q;
   reg  [7:0] scaler_q;
   reg  [7:0] count_q;
   reg  [7:0] count_d;
   reg  [7:0] bound_q;
   reg        irq_stat_q;
   reg        irq_mask_q;
   reg  [5:0] pre_cnt_q;
   reg  [4:0] scl_cnt_q;
   reg        wave_q;
   reg        pin0_q;
   reg        pin4_q;
   reg        src_tick;
   reg        pre_tick;
   reg        tick;
   reg        period_evt;
   reg        pwm_level;

   wire [3:0] src_sel  = control_q[`EBTP_CTL_SRC_HI:`EBTP_CTL_SRC_LO];
   wire [1:0] out_sel  = control_q[`EBTP_CTL_OUT_HI:`EBTP_CTL_OUT_LO];
   wire       pwm_mode = control_q[`EBTP_CTL_PWM];
   wire       res6     = scaler_q[`EBTP_SCL_RES6];
   wire [1:0] pre_sel  = scaler_q[`EBTP_SCL_PRE_HI:`EBTP_SCL_PRE_LO];
   wire [4:0] scl_div  = scaler_q[`EBTP_SCL_DIV_HI:`EBTP_SCL_DIV_LO];
   wire       wr_cnt   = i_wr && (i_addr == `EBTP_ADDR_COUNT);

   // ***************************************************
   // usage notes
   // ***************************************************
   // register map on the plain port, one byte each:
   //   0 control: 7:4 source, 3:2 route, 1 pwm mode
   //   1 scaler:  7 six bit resolution, 6:5 prescale, 4:0 scale
   //   2 count:   running counter, write to preset
   //   3 bound:   period in period mode, duty in pwm mode
   //   4 status:  bit 0 timer event, write one to clear
   //   5 mask:    bit 0 lets the status drive the irq pin
   // unmapped addresses read zero and ignore writes
   //
   // source codes:
   //   1 system clock, every cycle a source tick
   //   2 fast oscillator, 5 slow oscillator, as tick enables
   //   3 and 6 pin0 rising and falling edges
   //   4 and 7 pin4 rising and falling edges
   //   0 and all others stop the timer
   // oscillator ticks must already be one cycle wide and
   // synchronous; this block does not retime them
   // pin sources need each level held one cycle at least,
   // or an edge can slip between samples
   //
   // route codes:
   //   2 drives pin3, 3 drives pin4, 0 and 1 drive neither
   // a routed pin is driven whatever its direction setting
   //
   // tick chain:
   //   source tick -> prescale 1, 4, 16 or 64 -> scale n+1
   //   -> one counting tick of one system cycle
   // the prescaler runs free; a new prescale code takes effect
   // at its next wrap, not from a clean start
   //
   // period mode:
   //   counter climbs to the bound, clears, toggles the wave
   //   and sets the status flag on that same tick
   //   half period is bound plus one counting ticks
   // pwm mode:
   //   counter runs the full eight or six bit range
   //   wave high while count, or its low six bits, <= bound
   //   bound of 255 (eight bit) or 63 and up (six bit) stays high
   //   no event is raised, so status stays quiet in pwm
   //
   // all outputs leave flip-flops: pins, irq and the tick pulse
   // lag their internal cause by one system cycle
   // a count write wins over a tick in the same cycle, but a
   // bound match in that cycle still raises the event

   // ***************************************************
   // clock source selection
   // ***************************************************
   // pins are taken as synchronous; edges become one-cycle ticks
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pin0_q <= 1'b0;
         pin4_q <= 1'b0;
      end else begin
         pin0_q <= i_port_a_pin0;
         pin4_q <= i_port_a_pin4;
      end
   end

   // source tick per cycle; oscillators arrive as tick enables
   always @* begin
      case (src_sel)
         `EBTP_SRC_SYS:       src_tick = 1'b1;
         `EBTP_SRC_FAST:      src_tick = i_fast_osc_tick;
         `EBTP_SRC_SLOW:      src_tick = i_slow_osc_tick;
         `EBTP_SRC_PIN0_RISE: src_tick = i_port_a_pin0 & ~pin0_q;
         `EBTP_SRC_PIN0_FALL: src_tick = ~i_port_a_pin0 & pin0_q;
         `EBTP_SRC_PIN4_RISE: src_tick = i_port_a_pin4 & ~pin4_q;
         `EBTP_SRC_PIN4_FALL: src_tick = ~i_port_a_pin4 & pin4_q;
         default:             src_tick = 1'b0;
      endcase
   end

   // ***************************************************
   // prescaler and scaler
   // ***************************************************
   // prescale tick when the low bits of a free counter wrap
   always @* begin
      case (pre_sel)
         2'h0:    pre_tick = src_tick;
         2'h1:    pre_tick = src_tick && (pre_cnt_q[1:0] == 2'h3);
         2'h2:    pre_tick = src_tick && (pre_cnt_q[3:0] == 4'hf);
         default: pre_tick = src_tick && (pre_cnt_q == 6'h3f);
      endcase
      tick = pre_tick && (scl_cnt_q == scl_div);
   end

   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pre_cnt_q <= 6'h00;
         scl_cnt_q <= 5'h00;
      end else begin
         if (src_tick)
            pre_cnt_q <= pre_cnt_q + 6'h01;
         if (tick)
            scl_cnt_q <= 5'h00;
         else if (pre_tick)
            scl_cnt_q <= scl_cnt_q + 5'h01;
      end
   end

   // ***************************************************
   // counter and waveform
   // ***************************************************
   // bound compare sees the full byte in period mode
   always @* begin
      period_evt = tick && !pwm_mode && (count_q == bound_q);
      count_d    = count_q;
      if (wr_cnt)
         count_d = i_wdata;
      else if (period_evt)
         count_d = 8'h00;
      else if (tick && pwm_mode && res6 && (count_q[5:0] == 6'h3f))
         count_d = 8'h00;
      else if (tick)
         count_d = count_q + 8'h01;
      if (res6)
         pwm_level = ({2'h0, count_q[5:0]} <= bound_q);
      else
         pwm_level = (count_q <= bound_q);
   end

   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         count_q <= `EBTP_RST_BYTE;
         wave_q  <= 1'b0;
      end else begin
         count_q <= count_d;
         if (pwm_mode)
            wave_q <= pwm_level;
         else if (period_evt)
            wave_q <= ~wave_q;
      end
   end

   // ***************************************************
   // register port: decode
   // ***************************************************
   // one enable per register keeps each process below trivial;
   // unmapped addresses match none of them, so such writes vanish
   wire       wr_control = i_wr && (i_addr == `EBTP_ADDR_CONTROL);
   wire       wr_scaler  = i_wr && (i_addr == `EBTP_ADDR_SCALER);
   wire       wr_bound   = i_wr && (i_addr == `EBTP_ADDR_BOUND);
   wire       wr_stat    = i_wr && (i_addr == `EBTP_ADDR_IRQ_STAT);
   wire       wr_mask    = i_wr && (i_addr == `EBTP_ADDR_IRQ_MASK);
   reg  [7:0] rdata_d;

   // ***************************************************
   // configuration registers
   // ***************************************************
   // source, route and mode change together in one write;
   // the prescale and scale counts are not cleared here, so the first tick after
   // a change may come early by up to one whole counting tick span
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         control_q <= `EBTP_RST_BYTE;
      end else if (wr_control) begin
         control_q <= i_wdata;
      end
   end

   // resolution, prescale and scale share one byte
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         scaler_q <= `EBTP_RST_BYTE;
      end else if (wr_scaler) begin
         scaler_q <= i_wdata;
      end
   end

   // bound takes effect at once; a bound below the running count
   // in period mode lets the counter wrap through 255 first
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         bound_q <= `EBTP_RST_BYTE;
      end else if (wr_bound) begin
         bound_q <= i_wdata;
      end
   end

   // ***************************************************
   // interrupt status and mask
   // ***************************************************
   // mask only gates the output; status keeps recording events
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         irq_mask_q <= `EBTP_RST_IRQ;
      end else if (wr_mask) begin
         irq_mask_q <= i_wdata[0];
      end
   end

   // a fresh event beats a same-cycle clear so it is never lost;
   // writing a zero leaves the flag alone, so clears never race
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         irq_stat_q <= `EBTP_RST_IRQ;
      end else if (period_evt) begin
         irq_stat_q <= 1'b1;
      end else if (wr_stat && i_wdata[0]) begin
         irq_stat_q <= 1'b0;
      end
   end

   // ***************************************************
   // read port
   // ***************************************************
   // read mux; idle cycles and unmapped addresses give zero
   always @* begin
      rdata_d = 8'h00;
      if (i_rd) begin
         case (i_addr)
            `EBTP_ADDR_CONTROL:  rdata_d = control_q;
            `EBTP_ADDR_SCALER:   rdata_d = scaler_q;
            `EBTP_ADDR_COUNT:    rdata_d = count_q;
            `EBTP_ADDR_BOUND:    rdata_d = bound_q;
            `EBTP_ADDR_IRQ_STAT: rdata_d = {7'h00, irq_stat_q};
            `EBTP_ADDR_IRQ_MASK: rdata_d = {7'h00, irq_mask_q};
            default:             rdata_d = 8'h00;
         endcase
      end
   end

   // data stand for exactly one cycle after the strobe
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= rdata_d;
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   // registered so pins and irq never glitch; costs one cycle of lag
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= irq_stat_q & irq_mask_q;
      end
   end

   // one pulse per counting tick for the comparator sampling
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_scaled_timer_clock <= 1'b0;
      end else begin
         o_scaled_timer_clock <= tick;
      end
   end

   // both pins carry the wave; only the enables tell them apart
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_port_a_pin3_out  <= 1'b0;
         o_port_a_pin3_oe_n <= 1'b1;
      end else begin
         o_port_a_pin3_out  <= wave_q;
         o_port_a_pin3_oe_n <= (out_sel != `EBTP_OUT_PIN3);
      end
   end

   // pin4 enable ignores the direction the port would otherwise use
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_port_a_pin4_out  <= 1'b0;
         o_port_a_pin4_oe_n <= 1'b1;
      end else begin
         o_port_a_pin4_out  <= wave_q;
         o_port_a_pin4_oe_n <= (out_sel != `EBTP_OUT_PIN4);
      end
   end

endmodule // ebtp_timer

// file: rtl/ebtp_defs.vh
`ifndef EBTP_DEFS_VH
`define EBTP_DEFS_VH

// ***************************************************
// register addresses on the plain port
// ***************************************************
`define EBTP_ADDR_CONTROL   4'h0
`define EBTP_ADDR_SCALER    4'h1
`define EBTP_ADDR_COUNT     4'h2
`define EBTP_ADDR_BOUND     4'h3
`define EBTP_ADDR_IRQ_STAT  4'h4
`define EBTP_ADDR_IRQ_MASK  4'h5

// ***************************************************
// control register fields
// ***************************************************
`define EBTP_CTL_SRC_HI     7
`define EBTP_CTL_SRC_LO     4
`define EBTP_CTL_OUT_HI     3
`define EBTP_CTL_OUT_LO     2
`define EBTP_CTL_PWM        1

// ***************************************************
// scaler register fields
// ***************************************************
`define EBTP_SCL_RES6       7
`define EBTP_SCL_PRE_HI     6
`define EBTP_SCL_PRE_LO     5
`define EBTP_SCL_DIV_HI     4
`define EBTP_SCL_DIV_LO     0

// ***************************************************
// clock source codes
// ***************************************************
`define EBTP_SRC_STOP       4'h0
`define EBTP_SRC_SYS        4'h1
`define EBTP_SRC_FAST       4'h2
`define EBTP_SRC_PIN0_RISE  4'h3
`define EBTP_SRC_PIN4_RISE  4'h4
`define EBTP_SRC_SLOW       4'h5
`define EBTP_SRC_PIN0_FALL  4'h6
`define EBTP_SRC_PIN4_FALL  4'h7

// ***************************************************
// output route codes
// ***************************************************
`define EBTP_OUT_NONE       2'h0
`define EBTP_OUT_PIN3       2'h2
`define EBTP_OUT_PIN4       2'h3

// ***************************************************
// reset values
// ***************************************************
`define EBTP_RST_BYTE       8'h00
`define EBTP_RST_IRQ        1'b0

`endif

// file: tb/ebtp_timer_properties.sv
`timescale 1ns/1ps
// ****************************************
// port checks for the timer
// ****************************************
module ebtp_checker (
   input wire       i_mclk,
   input wire       i_rst,
   input wire [3:0] i_addr,
   input wire [7:0] i_wdata,
   input wire       i_wr,
   input wire       i_rd,
   input wire [7:0] o_rdata,
   input wire       o_irq,
   input wire       o_scaled_timer_clock,
   input wire       o_port_a_pin3_oe_n,
   input wire       o_port_a_pin4_oe_n
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   // read data only in the cycle after a read strobe
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not idle");
   a_cfg_readback: assert property (i_wr && (i_addr == 4'h1 || i_addr == 4'h3) ##1 !i_wr ##1
      i_rd && i_addr == $past(i_addr, 2) |=> o_rdata == $past(i_wdata, 3)) else $error("register readback wrong");
   // no tick in the gap cycle, so the written count must come back as is
   a_count_readback: assert property (i_wr && i_addr == 4'h2 ##1 !i_wr ##1
      i_rd && i_addr == 4'h2 && !o_scaled_timer_clock |=> o_rdata == $past(i_wdata, 3))
      else $error("count readback wrong");
   a_route_excl: assert property (o_port_a_pin3_oe_n || o_port_a_pin4_oe_n)
      else $error("both pins driven");
   // the route moves only after a control write
   a_route_change: assert property ($changed({o_port_a_pin3_oe_n, o_port_a_pin4_oe_n}) |->
      $past(i_wr && i_addr == 4'h0) || $past(i_wr && i_addr == 4'h0, 2)) else $error("route moved alone");
   a_mask_quiet: assert property ((i_wr && i_addr == 4'h5 && !i_wdata[0]) ##1 !(i_wr && i_addr == 4'h5)
      |=> !o_irq) else $error("masked irq high");
   a_irq_fall: assert property ($fell(o_irq) |-> $past(i_wr && (i_addr == 4'h4 || i_addr == 4'h5)) ||
      $past(i_wr && (i_addr == 4'h4 || i_addr == 4'h5), 2)) else $error("irq fell alone");
   a_irq_status: assert property (i_rd && i_addr == 4'h4 && o_irq && !$past(i_wr) |=> o_rdata[0])
      else $error("irq without status");
endmodule // ebtp_checker
bind ebtp_timer ebtp_checker ebtp_checker_inst (.*);

// file: tb/ebtp_timer_test.sv
`timescale 1ns/1ps
// ****************************************
// timer bench
// ****************************************
module ebtp_timer_test;
   reg        i_mclk, i_rst, i_wr, i_rd, i_fast_osc_tick, i_slow_osc_tick, i_port_a_pin0, i_port_a_pin4;
   reg  [3:0] i_addr;
   reg  [7:0] i_wdata;
   wire [7:0] o_rdata;
   wire       o_irq, o_scaled_timer_clock, o_port_a_pin3_out, o_port_a_pin3_oe_n;
   wire       o_port_a_pin4_out, o_port_a_pin4_oe_n;
   integer    n_mismatch, checked, hi, lo, k, j;
   reg  [3:0] src [0:5];
   ebtp_timer ebtp_timer_inst (.*);
   // clock and idle inputs
   initial begin
      {i_mclk, i_rst, i_wr, i_rd, i_fast_osc_tick, i_slow_osc_tick, i_port_a_pin0, i_port_a_pin4} = 8'h40;
      {i_addr, i_wdata} = 12'h000;
      forever #50 i_mclk = ~i_mclk;
   end
   task summarize;
      begin
         if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   task chk(input [15:0] seen, input [15:0] exp, input string name);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   // bus tasks start just after a rising edge and end just after one
   task wr(input [3:0] a, input [7:0] d);
      begin
         i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
         @(posedge i_mclk); i_wr <= 1'b0;
         @(posedge i_mclk);
      end
   endtask
   task rd(input [3:0] a, input [7:0] e, input string n);
      begin
         i_rd <= 1'b1; i_addr <= a;
         @(posedge i_mclk); i_rd <= 1'b0;
         @(negedge i_mclk); chk(o_rdata, e, n);
         @(posedge i_mclk);
      end
   endtask
   // one source event: pins get a whole pulse, ticks a single cycle
   task pulse(input integer s);
      begin
         if (s < 2) i_port_a_pin0 <= 1'b1; else if (s < 4) i_port_a_pin4 <= 1'b1;
         else if (s == 4) i_fast_osc_tick <= 1'b1; else i_slow_osc_tick <= 1'b1;
         repeat (s < 4 ? 2 : 1) @(posedge i_mclk);
         {i_port_a_pin0, i_port_a_pin4, i_fast_osc_tick, i_slow_osc_tick} <= 4'h0;
         repeat (2) @(posedge i_mclk);
      end
   endtask
   // high and low run lengths of the pin3 waveform, bounded
   task meas;
      begin
         for (k = 0; k < 3000 && o_port_a_pin3_out !== 1'b0; k++) @(negedge i_mclk);
         for (k = 0; k < 3000 && o_port_a_pin3_out !== 1'b1; k++) @(negedge i_mclk);
         for (hi = 0; hi < 3000 && o_port_a_pin3_out === 1'b1; hi++) @(negedge i_mclk);
         for (lo = 0; lo < 3000 && o_port_a_pin3_out === 1'b0; lo++) @(negedge i_mclk);
      end
   endtask
   // main sequence
   initial begin
      n_mismatch = 0; checked = 0;
      src[0] = 4'h3; src[1] = 4'h6; src[2] = 4'h4; src[3] = 4'h7; src[4] = 4'h2; src[5] = 4'h5;
      repeat (12) @(posedge i_mclk);
      i_rst <= 1'b0;
      @(posedge i_mclk);
      for (j = 0; j < 8; j++) rd(j[3:0], 8'h00, "reset value");
      chk({o_port_a_pin3_oe_n, o_port_a_pin4_oe_n}, 2'b11, "idle oe");
      wr(1, 8'h8a); rd(1, 8'h8a, "scaler");
      wr(3, 8'hc5); rd(3, 8'hc5, "bound");
      wr(0, 8'h0c); rd(0, 8'h0c, "control");
      chk({o_port_a_pin3_oe_n, o_port_a_pin4_oe_n}, 2'b10, "pin4 oe");
      wr(2, 8'h55); rd(2, 8'h55, "count");
      wr(1, 8'h00);
      for (j = 0; j < 6; j++) begin
         wr(0, {src[j], 4'h0}); wr(2, 8'h00);
         repeat (4) pulse(j);
         repeat (4) @(posedge i_mclk);
         rd(2, 8'h04, "source count");
      end
      wr(3, 8'h03); wr(0, 8'h18);
      for (j = 0; j < 4; j++) begin
         wr(1, {1'b0, j[1:0], 5'h02}); meas;
         chk(hi[15:0], 16'd12 << (2 * j), "half high");
         chk(lo[15:0], 16'd12 << (2 * j), "half low");
      end
      wr(3, 8'h00); wr(2, 8'h00); wr(1, 8'h1f); meas; chk(hi[15:0], 16'd32, "scale 31");
      chk(o_irq, 1'b0, "masked irq"); rd(4, 8'h01, "status");
      wr(5, 8'h01); repeat (3) @(posedge i_mclk); chk(o_irq, 1'b1, "irq");
      rd(4, 8'h01, "status"); wr(5, 8'h00); repeat (3) @(posedge i_mclk); chk(o_irq, 1'b0, "mask");
      wr(0, 8'h08); wr(4, 8'h01); wr(5, 8'h01); repeat (3) @(posedge i_mclk);
      chk(o_irq, 1'b0, "cleared irq"); rd(4, 8'h00, "status clear");
      chk(o_scaled_timer_clock, 1'b0, "tick stopped");
      wr(1, 8'h00); wr(3, 8'h09); wr(0, 8'h1a); meas;
      chk(hi[15:0], 16'd10, "pwm8 high"); chk(lo[15:0], 16'd246, "pwm8 low");
      chk({o_port_a_pin3_oe_n, o_port_a_pin4_oe_n}, 2'b01, "pin3 oe");
      wr(3, 8'hff); meas; chk(hi[15:0], 16'd3000, "pwm8 full");
      chk(o_port_a_pin4_out, 1'b1, "pin4 wave");
      wr(1, 8'h80); wr(3, 8'h1f); meas;
      chk(hi[15:0], 16'd32, "pwm6 high"); chk(lo[15:0], 16'd32, "pwm6 low");
      chk(o_scaled_timer_clock, 1'b1, "tick every cycle");
      summarize;
   end
   // watchdog against a hang
   initial begin
      #(100 * 60000);
      n_mismatch = n_mismatch + 1;
      summarize;
   end
endmodule // ebtp_timer_test
